// [bench/converter_serial_interface_tb_top.sv]
// Testbench of the converter serial interface with a codec model.
// Assumes the package, design, checker and model are compiled first.
`default_nettype none

module converter_serial_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_idle;
    logic [csi_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic bclk_out, bclk_oe, fs_out, fs_oe, sdo, sdo_oe, buffer_done;
    logic m_run, m_bclk, m_fs, m_sdi;
    logic [15:0] m_word, w;
    logic [16:0] exp_q[$];
    logic [16:0] msk_q[$];
    logic [16:0] e;
    int num_errors, comparisons, done_cnt, s;
    logic [7:0] regs[5] = '{csi_pkg::OFF_CTRL1, csi_pkg::OFF_CTRL2, csi_pkg::OFF_DIV, csi_pkg::OFF_STAT,
        csi_pkg::OFF_RXSLOT};
    logic [15:0] msks[5] = '{csi_pkg::CTRL1_MASK, csi_pkg::CTRL2_MASK, csi_pkg::DIV_MASK, 16'h0000, 16'hffff};

    converter_serial_interface u_converter_serial_interface (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_idle(cpu_idle), .bit_clock_pin_in(bclk_oe ? bclk_out : m_bclk),
        .bit_clock_pin_out(bclk_out), .bit_clock_pin_oe(bclk_oe),
        .frame_sync_pin_in(fs_oe ? fs_out : m_fs), .frame_sync_pin_out(fs_out),
        .frame_sync_pin_oe(fs_oe), .serial_in_pin(m_sdi), .serial_out_pin(sdo),
        .serial_out_pin_oe(sdo_oe), .buffer_done(buffer_done)
    );
    csi_codec_model u_csi_codec_model (.run(m_run), .word(m_word), .bclk(m_bclk), .fs(m_fs), .sdi(m_sdi));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ==========
    // Bus tasks and result checking
    task automatic check(input logic [16:0] seen, input logic [16:0] ex);
        comparisons++;
        if (seen !== ex) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, ex);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [16:0] ex, input logic [16:0] m);
        exp_q.push_back(ex & m);
        msk_q.push_back(m);
        xfer(1'b0, a, 16'h0000);
    endtask

    task automatic wait_done(input int n);
        int st;
        st = done_cnt;
        while (done_cnt < st + n) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            check({pslverr, prdata[15:0]} & msk_q.pop_front(), e);
        end
        if (buffer_done === 1'b1) done_cnt++;
    end

    // Loopback in master mode, random word, edge, justification, lengths
    task automatic loop_case(input logic [3:0] ws, input logic underflow_mode);
        logic [15:0] m;
        logic [1:0] fm;
        fm = 2'($urandom);
        m = fm[1] ? 16'hffff : 16'hffff << (4'hf - ws);
        w = 16'($urandom);
        xfer(1'b1, csi_pkg::OFF_CTRL1, 16'h0000);
        xfer(1'b1, csi_pkg::OFF_CTRL2, {4'h0, 2'($urandom), 1'b0, 4'($urandom_range(3)), 1'b0, ws});
        for (int i = 0; i < 4; i++) xfer(1'b1, csi_pkg::OFF_BUF + 8'h10 + 8'(4 * i), w);
        xfer(1'b1, csi_pkg::OFF_CTRL1, 16'h8800 | {8'h00, underflow_mode, 5'h00, fm} | (16'($urandom) & 16'h0220));
        wait_done(6);
        rd(csi_pkg::OFF_STAT, 17'h0000f, 17'h0000f);
        rd(csi_pkg::OFF_BUF, {1'b0, underflow_mode ? w & m : 16'h0000}, 17'h1ffff);
    endtask

    task automatic conclude;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        conclude();
    end

    // ==========
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        cpu_idle = 1'b0;
        m_run = 1'b0;
        m_word = 16'h0000;
        num_errors = 0;
        comparisons = 0;
        done_cnt = 0;
        void'($urandom(32'h956b2d97));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) begin
            w = (16'($urandom) & 16'h7fff) | 16'h0003;
            rd(regs[i], 17'h00000, 17'h1ffff);
            xfer(1'b1, regs[i], w);
            rd(regs[i], {1'b0, w & msks[i]}, 17'h1ffff);
        end
        rd(8'h18, 17'h10000, 17'h1ffff);
        rd(8'h02, 17'h10000, 17'h1ffff);
        xfer(1'b1, csi_pkg::OFF_DIV, 16'h0000);
        xfer(1'b1, csi_pkg::OFF_RXSLOT, 16'hffff);
        xfer(1'b1, csi_pkg::OFF_TXSLOT, 16'hffff);
        cpu_idle <= 1'b1;
        loop_case(4'hf, 1'b1);
        loop_case(4'h7, 1'b1);
        loop_case(4'h3, 1'b1);
        loop_case(4'hf, 1'b0);
        xfer(1'b1, csi_pkg::OFF_CTRL1, 16'ha800);
        repeat (3) @(posedge pclk);
        s = done_cnt;
        repeat (300) @(posedge pclk);
        check(17'(done_cnt - s), 17'h00000);
        cpu_idle <= 1'b0;
        wait_done(1);
        // Codec sources bit clock and frame sync
        xfer(1'b1, csi_pkg::OFF_CTRL1, 16'h0000);
        xfer(1'b1, csi_pkg::OFF_CTRL2, 16'h000f);
        m_word <= 16'($urandom);
        m_run <= 1'b1;
        xfer(1'b1, csi_pkg::OFF_CTRL1, 16'h8520);
        wait_done(4);
        rd(csi_pkg::OFF_BUF, {1'b0, m_word}, 17'h1ffff);
        conclude();
    end
endmodule

`default_nettype wire

// [bench/csi_codec_model.sv]
// Codec model: sources bit clock, frame sync and serial data.
// Assumes the interface samples on the falling bit-clock edge.
`default_nettype none

module csi_codec_model (
    input wire logic run,
    input wire logic [15:0] word,
    output logic bclk,
    output logic fs,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] bit_n;

    initial begin
        bclk = 1'b0;
        fs = 1'b0;
        sdi = 1'b0;
        bit_n = 4'hf;
        forever begin
            #160;
            if (run) begin
                bclk = ~bclk;
                if (bclk) begin
                    fs = (bit_n == 4'hf);
                    sdi = word[bit_n];
                    bit_n = bit_n - 4'h1;
                end
            end else begin
                // Clock stands still, released data keeps changing
                bclk = 1'b0;
                fs = 1'b0;
                sdi = ~sdi;
                bit_n = 4'hf;
            end
        end
    end
endmodule

`default_nettype wire

// [bench/csi_sva.sv]
// Port checker of the converter serial interface.
// Assumes it is bound to the design top and sees its ports only.
`default_nettype none

module csi_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bit_clock_pin_oe,
    input wire logic frame_sync_pin_oe,
    input wire logic serial_out_pin_oe,
    input wire logic buffer_done
);
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic acc;
    logic bad;
    logic en;

    // ==========
    // Shadow of control one
    assign acc = psel && penable && pready;
    assign bad = paddr[1:0] != 2'b00 || paddr > csi_pkg::OFF_BUF_END
        || (paddr > csi_pkg::OFF_TXSLOT && paddr < csi_pkg::OFF_BUF);
    assign ctl_d = (acc && pwrite && paddr == csi_pkg::OFF_CTRL1) ? pwdata[15:0] & csi_pkg::CTRL1_MASK : ctl_q;
    assign en = ctl_q[csi_pkg::CTL_ENABLE];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= csi_pkg::REG_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========
    // Properties
    a_bad_addr_err: assert property (psel && penable && bad |-> pslverr)
        else $error("no error on unmapped address");
    a_good_addr_ok: assert property (psel && penable && !bad |-> !pslverr)
        else $error("error on mapped address");
    a_upper_zero: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_ctl_readback: assert property (acc && !pwrite && paddr == csi_pkg::OFF_CTRL1 |-> prdata[15:0] == ctl_q)
        else $error("control one reads wrong");
    a_stat_reserved: assert property (
        acc && !pwrite && paddr == csi_pkg::OFF_STAT |-> prdata[15:12] == 4'h0 && prdata[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_off_quiet: assert property (
        !en && !$past(en) |-> !(bit_clock_pin_oe || frame_sync_pin_oe || serial_out_pin_oe))
        else $error("pin driven while disabled");
    a_bclk_dir: assert property (
        en && $stable(ctl_q) |-> bit_clock_pin_oe == !ctl_q[csi_pkg::CTL_BCLK_DIR])
        else $error("bit clock direction wrong");
    a_fs_dir: assert property (
        en && $stable(ctl_q) |-> frame_sync_pin_oe == !ctl_q[csi_pkg::CTL_FS_DIR])
        else $error("frame sync direction wrong");
    a_done_pulse: assert property (buffer_done |-> (en || $past(en)) ##1 !buffer_done)
        else $error("block pulse too long or while off");
endmodule

bind converter_serial_interface csi_sva u_csi_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock_pin_oe(bit_clock_pin_oe), .frame_sync_pin_oe(frame_sync_pin_oe),
    .serial_out_pin_oe(serial_out_pin_oe), .buffer_done(buffer_done)
);

`default_nettype wire

// [design/bit_clock_gen.sv]
// Bit-clock generator: half period of (divisor + 1) pclk cycles.
// Assumes run is held low while another party sources the bit clock.
`default_nettype none

module bit_clock_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [11:0] divisor,
    output logic clk_out,
    output csi_pkg::edge_t edges
);

    typedef struct packed {
        logic [11:0] cnt;
        logic clk;
        csi_pkg::edge_t edg;
    } gen_t;

    gen_t q;
    gen_t d;

    always_comb begin
        d = q;
        d.edg = '0;
        if (run) begin
            if (q.cnt >= divisor) begin
                d.cnt = 12'h000;
                d.clk = !q.clk;
                d.edg.rise = !q.clk;
                d.edg.fall = q.clk;
            end else begin
                d.cnt = q.cnt + 12'h001;
            end
        end else begin
            d.cnt = 12'h000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clk_out = q.clk;
    assign edges = q.edg;

endmodule

`default_nettype wire

// [design/converter_serial_interface.sv]
// Converter serial interface: APB registers, shared word buffer and serial frame engine.
// Assumes link pins are asynchronous to pclk and at most a quarter of pclk rate.
//
// Overview of operation
// - One 16-bit shift register serves both directions, MSb first.
// - Shared 2-bit word counter; address MSb 0 for receive, 1 for transmit.
// - Module runs only while control one bit 15 is set.
// - Idle-stop bit 13 halts the module while the processor idles.
// - Loopback bit 11 feeds the serial output back to the input.
// - Bit 10 set makes bit clock an input, clear drives it.
// - Bit 9 set: change on falling, sample on rising; clear: opposite.
// - Bit 8 set makes frame sync an input, clear drives it.
// - Transmit underflow sends last written word if bit 7 set, else zeros.
// - Disabled transmit slots float output if bit 6 set, else drive low.
// - Bit 5 set starts words with frame sync, clear one clock later.
// - Frame mode: 11 AC-Link 20, 10 AC-Link 16, 01 I2S, 00 multi-channel.
// - Buffer length field bits 11-10 gives one to four words per block.
// - In multi-channel mode, frame length field plus one gives slots per frame, up to sixteen.
// - Outside AC-Link modes, word size field plus one gives bits per word, one to sixteen.
// - Status bits 11-8 show the active slot index.
// - Status bit 3 flags a receive overflow.
// - Status bit 2 flags unread new receive data.
// - Status bit 1 flags a transmit underflow.
// - Status bit 0 flags empty transmit registers.
// - Receive slot enable bits select which slots capture input.
// - Transmit slot enable bits select which slots send buffered data.
// - Words are left-justified; short received words get zero low bits.
`default_nettype none

module converter_serial_interface (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_idle,
    input wire logic bit_clock_pin_in,
    output logic bit_clock_pin_out,
    output logic bit_clock_pin_oe,
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_pin_oe,
    output logic buffer_done
);

    typedef struct packed {
        logic [15:0] ctrl1;
        logic [15:0] ctrl2;
        logic [15:0] div;
        logic [15:0] rxslot;
        logic [15:0] txslot;
        logic [7:0][15:0] buf_w;
        logic [15:0] last_wr;
        logic receive_overflow;
        logic receive_full;
        logic transmit_underflow;
        logic tempty;
        logic [15:0] sh;
        logic [1:0] wc;
        logic [3:0] slot;
        logic [4:0] bitc;
        logic [8:0] fpos;
        logic in_frame;
        logic pend;
        logic started;
        logic bclk_prev;
        logic fs_prev;
        logic sdo;
        logic sdo_oe;
        logic fs_out;
        logic done;
        logic [31:0] prdata;
    } state_t;

    state_t q;
    state_t d;

    // ==========================================================
    // Pin synchronisers and bit-clock generator
    csi_pkg::link_in_t lk;
    csi_pkg::edge_t gen_edges;
    logic gen_clk;
    logic enable;
    logic run;
    logic master_bclk;
    logic master_fs;

    pin_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({bit_clock_pin_in, frame_sync_pin_in, serial_in_pin}),
        .sync_out(lk)
    );

    assign enable = q.ctrl1[csi_pkg::CTL_ENABLE];
    assign run = enable && !(q.ctrl1[csi_pkg::CTL_IDLE_STOP] && cpu_idle);
    assign master_bclk = !q.ctrl1[csi_pkg::CTL_BCLK_DIR];
    assign master_fs = !q.ctrl1[csi_pkg::CTL_FS_DIR];

    bit_clock_gen u_bclk (
        .pclk(pclk),
        .presetn(presetn),
        .run(run && master_bclk),
        .divisor(q.div[11:0]),
        .clk_out(gen_clk),
        .edges(gen_edges)
    );

    // ==========================================================
    // Framing geometry
    csi_pkg::fs_mode_t mode;
    logic is_ac;
    logic [4:0] wlen;
    logic [4:0] nslots;
    logic [4:0] slot_len;
    logic [4:0] dbits;
    logic [8:0] frame_bits;
    logic [2:0] buffer_length;

    always_comb begin
        mode = csi_pkg::fs_mode_t'(q.ctrl1[csi_pkg::CTL_FSM_LSB +: 2]);
        is_ac = (mode == csi_pkg::FS_AC16) || (mode == csi_pkg::FS_AC20);
        wlen = {1'b0, q.ctrl2[csi_pkg::CTL2_WS_LSB +: 4]} + 5'd1;
        buffer_length = {1'b0, q.ctrl2[csi_pkg::CTL2_BUFFER_LENGTH_LSB +: 2]} + 3'd1;
        case (mode)
            csi_pkg::FS_MULTI: begin
                nslots = {1'b0, q.ctrl2[csi_pkg::CTL2_FLEN_LSB +: 4]} + 5'd1;
                slot_len = wlen;
                dbits = wlen;
                frame_bits = 9'(nslots * wlen);
            end
            csi_pkg::FS_I2S: begin
                nslots = csi_pkg::I2S_SLOTS;
                slot_len = wlen;
                dbits = wlen;
                frame_bits = 9'(nslots * wlen);
            end
            default: begin
                nslots = csi_pkg::AC_SLOTS;
                slot_len = (q.slot == 4'h0) ? csi_pkg::AC_SLOT0_BITS : csi_pkg::AC_SLOT_BITS;
                dbits = csi_pkg::WORD_BITS;
                frame_bits = csi_pkg::AC_FRAME_BITS;
            end
        endcase
    end

    // ==========================================================
    // Register read mux
    function automatic logic [15:0] read_reg(input state_t s, input logic [7:0] a);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            csi_pkg::OFF_CTRL1: r = s.ctrl1;
            csi_pkg::OFF_CTRL2: r = s.ctrl2;
            csi_pkg::OFF_DIV: r = s.div;
            csi_pkg::OFF_RXSLOT: r = s.rxslot;
            csi_pkg::OFF_TXSLOT: r = s.txslot;
            csi_pkg::OFF_STAT: begin
                r[csi_pkg::STAT_SLOT_LSB +: 4] = s.slot;
                r[csi_pkg::STAT_ROV] = s.receive_overflow;
                r[csi_pkg::STAT_RECEIVE_FULL] = s.receive_full;
                r[csi_pkg::STAT_TRANSMIT_UNDERFLOW] = s.transmit_underflow;
                r[csi_pkg::STAT_TEMPTY] = s.tempty;
            end
            default: begin
                if (a >= csi_pkg::OFF_BUF && a <= csi_pkg::OFF_BUF_END) begin
                    r = s.buf_w[a[4:2]];
                end
            end
        endcase
        return r;
    endfunction

    logic [7:0] addr;
    logic hit;
    logic acc;
    logic bclk_rise;
    logic bclk_fall;
    logic drive_edge;
    logic samp_edge;
    logic fs_start;
    logic fstart;
    logic begin_word;
    logic load;
    logic [3:0] ld_slot;
    logic [15:0] word;
    logic [15:0] rx_word;
    logic sdi_bit;
    logic just;

    always_comb begin
        d = q;
        d.done = 1'b0;
        fstart = 1'b0;
        begin_word = 1'b0;
        load = 1'b0;
        ld_slot = 4'h0;
        word = 16'h0000;
        rx_word = 16'h0000;
        just = q.ctrl1[csi_pkg::CTL_JUST];
        addr = 8'(paddr);
        hit = (addr[1:0] == 2'b00) && (addr <= csi_pkg::OFF_TXSLOT
            || (addr >= csi_pkg::OFF_BUF && addr <= csi_pkg::OFF_BUF_END));
        acc = psel && penable && hit;

        // ==========================================================
        // APB slave: read data set up, write and read side effects
        if (psel && !penable) begin
            d.prdata = {16'h0000, read_reg(q, addr)};
        end
        if (acc && pwrite) begin
            case (addr)
                csi_pkg::OFF_CTRL1: d.ctrl1 = pwdata[15:0] & csi_pkg::CTRL1_MASK;
                csi_pkg::OFF_CTRL2: d.ctrl2 = pwdata[15:0] & csi_pkg::CTRL2_MASK;
                csi_pkg::OFF_DIV: d.div = pwdata[15:0] & csi_pkg::DIV_MASK;
                csi_pkg::OFF_RXSLOT: d.rxslot = pwdata[15:0];
                csi_pkg::OFF_TXSLOT: d.txslot = pwdata[15:0];
                default: begin
                    if (addr[4]) begin
                        d.buf_w[addr[4:2]] = pwdata[15:0];
                        d.last_wr = pwdata[15:0];
                        d.tempty = 1'b0;
                    end
                end
            endcase
        end
        if (acc && !pwrite) begin
            if (addr == csi_pkg::OFF_STAT) begin
                // Clear only what the setup cycle reported, so a late event is kept
                d.receive_overflow = q.receive_overflow && !q.prdata[csi_pkg::STAT_ROV];
                d.transmit_underflow = q.transmit_underflow && !q.prdata[csi_pkg::STAT_TRANSMIT_UNDERFLOW];
            end else if (addr >= csi_pkg::OFF_BUF && !addr[4]) begin
                d.receive_full = 1'b0;
            end
        end

        // ==========================================================
        // Link edges: own generator or synchronised pin
        d.bclk_prev = lk.bclk;
        bclk_rise = master_bclk ? gen_edges.rise : (lk.bclk && !q.bclk_prev);
        bclk_fall = master_bclk ? gen_edges.fall : (!lk.bclk && q.bclk_prev);
        drive_edge = run && (q.ctrl1[csi_pkg::CTL_EDGE] ? bclk_fall : bclk_rise);
        samp_edge = run && (q.ctrl1[csi_pkg::CTL_EDGE] ? bclk_rise : bclk_fall);
        fs_start = (mode == csi_pkg::FS_I2S) ? (!lk.fs && q.fs_prev) : (lk.fs && !q.fs_prev);
        sdi_bit = q.ctrl1[csi_pkg::CTL_LOOP] ? q.sdo : lk.sdi;

        // ==========================================================
        // Drive edge: frame position, slot stepping, word loading
        if (drive_edge) begin
            d.fs_prev = lk.fs;
            fstart = master_fs ? (!q.started || q.fpos == frame_bits - 9'd1) : fs_start;
            d.started = 1'b1;
            if (fstart) begin
                d.fpos = 9'h000;
            end else if (q.fpos != 9'h1ff) begin
                d.fpos = q.fpos + 9'd1;
            end
            if (master_fs) begin
                case (mode)
                    csi_pkg::FS_MULTI: d.fs_out = (d.fpos == 9'h000);
                    csi_pkg::FS_I2S: d.fs_out = (d.fpos >= {4'h0, wlen});
                    default: d.fs_out = (d.fpos < {4'h0, csi_pkg::AC_SLOT0_BITS});
                endcase
            end
            begin_word = (fstart && just) || q.pend;
            d.pend = fstart && !just;
            if (begin_word) begin
                d.slot = 4'h0;
                d.bitc = 5'd0;
                d.in_frame = 1'b1;
                load = 1'b1;
            end else if (q.in_frame) begin
                if (q.bitc == slot_len - 5'd1) begin
                    d.bitc = 5'd0;
                    if ({1'b0, q.slot} == nslots - 5'd1) begin
                        d.in_frame = 1'b0;
                    end else begin
                        d.slot = q.slot + 4'h1;
                        load = 1'b1;
                    end
                end else begin
                    d.bitc = q.bitc + 5'd1;
                end
            end
            ld_slot = d.slot;
            if (load) begin
                if (q.txslot[ld_slot]) begin
                    if (q.tempty) begin
                        d.transmit_underflow = 1'b1;
                        word = q.ctrl1[csi_pkg::CTL_UNF_MODE] ? q.last_wr : 16'h0000;
                    end else begin
                        word = q.buf_w[{1'b1, q.wc}];
                    end
                    d.sdo_oe = 1'b1;
                end else begin
                    d.sdo_oe = !q.ctrl1[csi_pkg::CTL_OUT_IDLE];
                end
                d.sh = word;
                d.sdo = word[15];
            end else if (d.in_frame && d.bitc < dbits) begin
                d.sdo = q.sh[15] && q.txslot[q.slot];
            end else begin
                d.sdo = 1'b0;
                if (!d.in_frame) begin
                    d.sdo_oe = !q.ctrl1[csi_pkg::CTL_OUT_IDLE];
                end
            end
        end

        // ==========================================================
        // Sample edge: shift in, store word, advance shared counter
        if (samp_edge && q.in_frame && q.bitc < dbits) begin
            d.sh = {q.sh[14:0], sdi_bit};
            if (q.bitc == dbits - 5'd1) begin
                rx_word = d.sh << (5'd16 - dbits);
                if (q.rxslot[q.slot]) begin
                    d.buf_w[{1'b0, q.wc}] = rx_word;
                end
                if (q.rxslot[q.slot] || q.txslot[q.slot]) begin
                    if ({1'b0, q.wc} == buffer_length - 3'd1) begin
                        d.wc = 2'b00;
                        d.done = 1'b1;
                        d.receive_overflow = q.receive_overflow || q.receive_full;
                        d.receive_full = 1'b1;
                        d.tempty = 1'b1;
                    end else begin
                        d.wc = q.wc + 2'b01;
                    end
                end
            end
        end

        // Disabled module returns the engine to idle
        if (!enable) begin
            d.started = 1'b0;
            d.in_frame = 1'b0;
            d.pend = 1'b0;
            d.wc = 2'b00;
            d.slot = 4'h0;
            d.bitc = 5'd0;
            d.fpos = 9'h000;
            d.sdo = 1'b0;
            d.sdo_oe = 1'b0;
            d.fs_out = 1'b0;
        end
    end

    // Idle-stop freezes the engine because run gates both edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = q.prdata;
    assign buffer_done = q.done;
    assign bit_clock_pin_out = gen_clk;
    assign bit_clock_pin_oe = enable && master_bclk;
    assign frame_sync_pin_out = q.fs_out;
    assign frame_sync_pin_oe = enable && master_fs;
    assign serial_out_pin = q.sdo;
    assign serial_out_pin_oe = enable && q.sdo_oe;

endmodule

`default_nettype wire

// [design/pin_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk.
`default_nettype none

module pin_sync #(
    parameter int W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// [include/csi_pkg.sv]
// Shared constants and carrier types of the converter serial interface.
// Assumes a 25 MHz APB clock and 16-bit registers in the low half of each word.
`default_nettype none

package csi_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_DIV = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_RXSLOT = 8'h10;
    localparam logic [7:0] OFF_TXSLOT = 8'h14;
    localparam logic [7:0] OFF_BUF = 8'h20;
    localparam logic [7:0] OFF_BUF_END = 8'h3c;

    // ==========================================================
    // Field positions
    localparam int CTL_ENABLE = 15;
    localparam int CTL_IDLE_STOP = 13;
    localparam int CTL_LOOP = 11;
    localparam int CTL_BCLK_DIR = 10;
    localparam int CTL_EDGE = 9;
    localparam int CTL_FS_DIR = 8;
    localparam int CTL_UNF_MODE = 7;
    localparam int CTL_OUT_IDLE = 6;
    localparam int CTL_JUST = 5;
    localparam int CTL_FSM_LSB = 0;
    localparam int CTL2_BUFFER_LENGTH_LSB = 10;
    localparam int CTL2_FLEN_LSB = 5;
    localparam int CTL2_WS_LSB = 0;
    localparam int STAT_SLOT_LSB = 8;
    localparam int STAT_ROV = 3;
    localparam int STAT_RECEIVE_FULL = 2;
    localparam int STAT_TRANSMIT_UNDERFLOW = 1;
    localparam int STAT_TEMPTY = 0;

    // ==========================================================
    // Writable masks and reset values
    localparam logic [15:0] CTRL1_MASK = 16'hafe3;
    localparam logic [15:0] CTRL2_MASK = 16'h0def;
    localparam logic [15:0] DIV_MASK = 16'h0fff;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ==========================================================
    // Framing figures
    localparam logic [4:0] WORD_BITS = 5'd16;
    localparam logic [4:0] AC_SLOT0_BITS = 5'd16;
    localparam logic [4:0] AC_SLOT_BITS = 5'd20;
    localparam logic [4:0] AC_SLOTS = 5'd13;
    localparam logic [4:0] I2S_SLOTS = 5'd2;
    localparam logic [8:0] AC_FRAME_BITS = 9'h100;

    typedef enum logic [1:0] {
        FS_MULTI = 2'b00,
        FS_I2S = 2'b01,
        FS_AC16 = 2'b10,
        FS_AC20 = 2'b11
    } fs_mode_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_t;

    typedef struct packed {
        logic bclk;
        logic fs;
        logic sdi;
    } link_in_t;

endpackage

`default_nettype wire
